/* mrx_defines.svh */
//----------------------------------------------------------------------------
// Purpose: constants of the move / return instruction executor
// Assumes: 32-bit AHB-Lite register bus, byte addresses, one word per reg
// Notes:   offsets, field positions, opcodes and reset values live here
//----------------------------------------------------------------------------
// Overview of operation
// - bank literal loads bank select, flags kept
// - latch literal loads pc high latch, flags kept
// - accumulator literal load, one cycle, no flags
// - accumulator stored to file register, one cycle
// - indirect store, pointer updated by mode field
// - relative store uses pointer plus offset, unchanged
// - indirect port redirects to pointer address
// - sixteen-bit pointer wraps at both ends
// - pointer updates and stores keep status flags
// - option load copies accumulator to option register
// - software reset resets device, clears reset flag
// - interrupt return pops stack, two cycles
// - interrupt return sets global interrupt enable
`ifndef MRX_DEFINES_SVH
`define MRX_DEFINES_SVH

//----------------------------------------------------------------------------
// register byte offsets
//----------------------------------------------------------------------------
`define MRX_OFF_INSTR 8'h00
`define MRX_OFF_ACC 8'h04
`define MRX_OFF_BANK 8'h08
`define MRX_OFF_PCLATCH 8'h0C
`define MRX_OFF_PTR0 8'h10
`define MRX_OFF_PTR1 8'h14
`define MRX_OFF_OPTION 8'h18
`define MRX_OFF_PWRCTL 8'h1C
`define MRX_OFF_IRQCTL 8'h20
`define MRX_OFF_PC 8'h24
`define MRX_OFF_STATUS 8'h28
`define MRX_OFF_CORE 8'h2C

//----------------------------------------------------------------------------
// instruction word fields and opcodes
//----------------------------------------------------------------------------
`define MRX_OP_HI 15
`define MRX_OP_LO 12
`define MRX_OP_NOP 4'h0
`define MRX_OP_LOAD_BANK 4'h1
`define MRX_OP_LOAD_LATCH 4'h2
`define MRX_OP_LOAD_ACC 4'h3
`define MRX_OP_STORE_FILE 4'h4
`define MRX_OP_STORE_IND 4'h5
`define MRX_OP_STORE_REL 4'h6
`define MRX_OP_OPTION 4'h7
`define MRX_OP_SW_RESET 4'h8
`define MRX_OP_RET_IRQ 4'h9
`define MRX_IND_SEL_BIT 8
`define MRX_REL_SEL_BIT 6
`define MRX_PORT0_ADDR 7'h00
`define MRX_PORT1_ADDR 7'h01
`define MRX_IRQ_EN_BIT 7
`define MRX_RI_FLAG_BIT 2

//----------------------------------------------------------------------------
// reset values
//----------------------------------------------------------------------------
`define MRX_RST_ACC 8'h00
`define MRX_RST_BANK 5'h00
`define MRX_RST_LATCH 7'h00
`define MRX_RST_PTR 16'h0000
`define MRX_RST_OPTION 8'hFF
`define MRX_RST_IRQCTL 8'h00
`define MRX_RST_STATUS 8'h18

`endif

/* mrx_pkg.sv */
//----------------------------------------------------------------------------
// Purpose: shared types of the move / return instruction executor
// Assumes: used by scoped reference only, never imported
// Notes:   numbers stay in mrx_defines.svh
//----------------------------------------------------------------------------
`default_nettype none

package mrx_pkg;
    // executor sequencing states
    typedef enum logic [1:0] {
        MRX_IDLE,
        MRX_EXEC,
        MRX_RET2
    } mrx_state_t;

    // pointer update modes of the indirect store
    typedef enum logic [1:0] {
        MRX_PRE_INC,
        MRX_PRE_DEC,
        MRX_POST_INC,
        MRX_POST_DEC
    } mrx_ptr_mode_t;
endpackage

`default_nettype wire

/* mrx_ptr_calc.sv */
//----------------------------------------------------------------------------
// Purpose: effective address and new pointer for an indirect store
// Assumes: purely combinational, pointer is 16 bits
// Notes:   arithmetic is modulo 2^16 so both ends wrap
//----------------------------------------------------------------------------
`default_nettype none

module mrx_ptr_calc (
    input wire logic [15:0] ptr_i, // current pointer value
    input wire logic rel_i, // relative-offset form
    input wire logic [1:0] ptr_update_mode_i, // mode field
    input wire logic [5:0] off_i, // signed offset
    output logic [15:0] addr_o, // effective address
    output logic [15:0] ptr_nxt_o // pointer after the store
);
    logic [15:0] inc_v; // pointer plus one
    logic [15:0] dec_v; // pointer minus one
    logic [15:0] sext_v; // sign extended offset

    // the sum is cut to 16 bits on purpose: that cut is the wrap
    always_comb begin
        inc_v = 16'(ptr_i + 16'h0001);
        dec_v = 16'(ptr_i - 16'h0001);
        sext_v = {{10{off_i[5]}}, off_i};
        if (rel_i) begin
            // pointer is left as it was
            addr_o = 16'(ptr_i + sext_v);
            ptr_nxt_o = ptr_i;
        end else begin
            case (mrx_pkg::mrx_ptr_mode_t'(ptr_update_mode_i))
                mrx_pkg::MRX_PRE_INC: begin
                    addr_o = inc_v;
                    ptr_nxt_o = inc_v;
                end
                mrx_pkg::MRX_PRE_DEC: begin
                    addr_o = dec_v;
                    ptr_nxt_o = dec_v;
                end
                mrx_pkg::MRX_POST_INC: begin
                    addr_o = ptr_i;
                    ptr_nxt_o = inc_v;
                end
                default: begin
                    addr_o = ptr_i;
                    ptr_nxt_o = dec_v;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

/* mrx_exec.sv */
//----------------------------------------------------------------------------
// Purpose: executes the literal, store, option, reset and irq return moves
// Assumes: AHB-Lite slave with zero wait states, one clock, sync reset
// Notes:   an instruction word written to the instruction register runs
//          in the following cycle; memory stores leave on the mem_ ports
//----------------------------------------------------------------------------
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`include "mrx_defines.svh"
`default_nettype none

module mrx_exec #(
    parameter int PC_W = 15 // program counter width
) (
    input wire logic clk_i, // core clock, 250 MHz
    input wire logic sys_rst_i, // synchronous reset, active high
    input wire logic hsel_i, // ahb slave select
    input wire logic [31:0] haddr_i, // ahb address
    input wire logic [1:0] htrans_i, // ahb transfer type
    input wire logic hwrite_i, // ahb write
    input wire logic [2:0] hsize_i, // ahb size, word only
    input wire logic [31:0] hwdata_i, // ahb write data
    input wire logic hready_i, // ahb bus ready
    output logic [31:0] hrdata_o, // ahb read data
    output logic hreadyout_o, // ahb slave ready
    output logic hresp_o, // ahb response, always okay
    input wire logic [PC_W-1:0] stack_top_i, // top entry of the stack
    output logic stack_pop_o, // one-cycle pop request
    output logic [PC_W-1:0] pc_o, // program counter
    output logic mem_we_o, // one-cycle data store strobe
    output logic [15:0] mem_addr_o, // data store address
    output logic [7:0] mem_wdata_o, // data store value
    output logic dev_reset_req_o, // one-cycle device reset request
    output logic global_irq_enable_o // global interrupt enable level
);
    //------------------------------------------------------------------------
    // elaboration check
    //------------------------------------------------------------------------
    if (PC_W < 8 || PC_W > 16) begin : g_bad_pc_w
        $error("mrx_exec: PC_W must be 8 to 16");
    end

    //------------------------------------------------------------------------
    // bus state
    //------------------------------------------------------------------------
    logic dph_wr_r; // data phase of a write is pending
    logic dph_wr_nxt;
    logic [7:0] dph_addr_r; // byte address of that write
    logic [7:0] dph_addr_nxt;
    logic [31:0] hrdata_r; // read data, valid in the data phase
    logic [31:0] hrdata_nxt;
    logic hreadyout_r; // never stretched
    logic hresp_r; // always okay
    logic aph_v; // a valid address phase is accepted

    //------------------------------------------------------------------------
    // core state
    //------------------------------------------------------------------------
    mrx_pkg::mrx_state_t state_r; // sequencing state
    mrx_pkg::mrx_state_t state_nxt;
    logic [15:0] instr_r; // instruction being run
    logic [15:0] instr_nxt;
    logic [7:0] acc_r; // accumulator
    logic [7:0] acc_nxt;
    logic [4:0] bank_select_reg_r; // bank select
    logic [4:0] bank_select_reg_nxt;
    logic [6:0] pc_high_latch_r; // pc high latch
    logic [6:0] pc_high_latch_nxt;
    logic [15:0] pointer_reg_r [2]; // the two pointers
    logic [15:0] pointer_reg_nxt [2];
    logic [7:0] option_r; // option configuration
    logic [7:0] option_nxt;
    logic reset_instr_flag_r; // low after a software reset
    logic reset_instr_flag_nxt;
    logic [7:0] irq_control_reg_r; // irq control, bit 7 is the enable
    logic [7:0] irq_control_reg_nxt;
    logic [PC_W-1:0] pc_r; // program counter
    logic [PC_W-1:0] pc_nxt;
    logic [7:0] status_r; // status flags, changed only by bus writes and software reset
    logic [7:0] status_nxt;
    logic mem_we_r; // store strobe
    logic mem_we_nxt;
    logic [15:0] mem_addr_r; // store address
    logic [15:0] mem_addr_nxt;
    logic [7:0] mem_wdata_r; // store value
    logic [7:0] mem_wdata_nxt;
    logic stack_pop_r; // pop strobe
    logic stack_pop_nxt;
    logic dev_reset_r; // reset request strobe
    logic dev_reset_nxt;

    //------------------------------------------------------------------------
    // decode helpers
    //------------------------------------------------------------------------
    logic [3:0] op_w; // opcode field
    logic sel_w; // pointer number of the indirect store
    logic [15:0] sel_ptr_w; // the selected pointer
    logic [15:0] ind_addr_w; // effective address from the calculator
    logic [15:0] ind_ptr_w; // pointer value after the store
    logic [6:0] file_w; // file operand of the direct store
    logic busy_w; // an instruction is still running

    assign op_w = instr_r[`MRX_OP_HI:`MRX_OP_LO];
    assign file_w = instr_r[6:0];
    assign busy_w = (state_r != mrx_pkg::MRX_IDLE);
    // the relative form carries its pointer number lower in the word
    assign sel_w = (op_w == `MRX_OP_STORE_REL) ?
        instr_r[`MRX_REL_SEL_BIT] : instr_r[`MRX_IND_SEL_BIT];
    assign sel_ptr_w = pointer_reg_r[sel_w];
    assign aph_v = hsel_i && htrans_i[1] && hready_i;

    // address and pointer arithmetic lives in its own small unit
    mrx_ptr_calc u_ptr_calc (
        .ptr_i(sel_ptr_w),
        .rel_i(op_w == `MRX_OP_STORE_REL),
        .ptr_update_mode_i(instr_r[1:0]),
        .off_i(instr_r[5:0]),
        .addr_o(ind_addr_w),
        .ptr_nxt_o(ind_ptr_w)
    );

    //------------------------------------------------------------------------
    // bus slave: next values
    //------------------------------------------------------------------------
    // read data is chosen in the address phase from the current registers,
    // so hrdata comes straight from a flop in the data phase
    always_comb begin
        dph_wr_nxt = aph_v && hwrite_i;
        dph_addr_nxt = haddr_i[7:0];
        hrdata_nxt = 32'h0000_0000;
        if (aph_v && !hwrite_i) begin
            if (haddr_i[7:0] == `MRX_OFF_INSTR) begin
                hrdata_nxt = {16'h0000, instr_r};
            end else if (haddr_i[7:0] == `MRX_OFF_ACC) begin
                hrdata_nxt = {24'h00_0000, acc_r};
            end else if (haddr_i[7:0] == `MRX_OFF_BANK) begin
                hrdata_nxt = {27'h000_0000, bank_select_reg_r};
            end else if (haddr_i[7:0] == `MRX_OFF_PCLATCH) begin
                hrdata_nxt = {25'h000_0000, pc_high_latch_r};
            end else if (haddr_i[7:0] == `MRX_OFF_PTR0) begin
                hrdata_nxt = {16'h0000, pointer_reg_r[0]};
            end else if (haddr_i[7:0] == `MRX_OFF_PTR1) begin
                hrdata_nxt = {16'h0000, pointer_reg_r[1]};
            end else if (haddr_i[7:0] == `MRX_OFF_OPTION) begin
                hrdata_nxt = {24'h00_0000, option_r};
            end else if (haddr_i[7:0] == `MRX_OFF_PWRCTL) begin
                hrdata_nxt[`MRX_RI_FLAG_BIT] = reset_instr_flag_r;
            end else if (haddr_i[7:0] == `MRX_OFF_IRQCTL) begin
                hrdata_nxt = {24'h00_0000, irq_control_reg_r};
            end else if (haddr_i[7:0] == `MRX_OFF_PC) begin
                hrdata_nxt[PC_W-1:0] = pc_r;
            end else if (haddr_i[7:0] == `MRX_OFF_STATUS) begin
                hrdata_nxt = {24'h00_0000, status_r};
            end else if (haddr_i[7:0] == `MRX_OFF_CORE) begin
                hrdata_nxt[0] = busy_w;
            end else begin
                // unmapped offsets read as zero with an okay response
                hrdata_nxt = 32'h0000_0000;
            end
        end
    end

    //------------------------------------------------------------------------
    // bus slave: registers
    //------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dph_wr_r <= 1'b0;
            dph_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            dph_wr_r <= dph_wr_nxt;
            dph_addr_r <= dph_addr_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    //------------------------------------------------------------------------
    // core: next values
    //------------------------------------------------------------------------
    // bus writes are applied first and an executing instruction after them,
    // so the instruction wins a clash on the same register in one cycle
    always_comb begin
        state_nxt = state_r;
        instr_nxt = instr_r;
        acc_nxt = acc_r;
        bank_select_reg_nxt = bank_select_reg_r;
        pc_high_latch_nxt = pc_high_latch_r;
        pointer_reg_nxt[0] = pointer_reg_r[0];
        pointer_reg_nxt[1] = pointer_reg_r[1];
        option_nxt = option_r;
        reset_instr_flag_nxt = reset_instr_flag_r;
        irq_control_reg_nxt = irq_control_reg_r;
        pc_nxt = pc_r;
        status_nxt = status_r;
        mem_we_nxt = 1'b0;
        mem_addr_nxt = mem_addr_r;
        mem_wdata_nxt = mem_wdata_r;
        stack_pop_nxt = 1'b0;
        dev_reset_nxt = 1'b0;

        // software register writes in the data phase
        if (dph_wr_r) begin
            if (dph_addr_r == `MRX_OFF_INSTR) begin
                // a new word is refused while one is still running
                if (!busy_w) begin
                    instr_nxt = hwdata_i[15:0];
                    state_nxt = mrx_pkg::MRX_EXEC;
                end
            end else if (dph_addr_r == `MRX_OFF_ACC) begin
                acc_nxt = hwdata_i[7:0];
            end else if (dph_addr_r == `MRX_OFF_PTR0) begin
                pointer_reg_nxt[0] = hwdata_i[15:0];
            end else if (dph_addr_r == `MRX_OFF_PTR1) begin
                pointer_reg_nxt[1] = hwdata_i[15:0];
            end else if (dph_addr_r == `MRX_OFF_PWRCTL) begin
                reset_instr_flag_nxt = hwdata_i[`MRX_RI_FLAG_BIT];
            end else if (dph_addr_r == `MRX_OFF_IRQCTL) begin
                irq_control_reg_nxt = hwdata_i[7:0];
            end else if (dph_addr_r == `MRX_OFF_STATUS) begin
                status_nxt = hwdata_i[7:0];
            end else begin
                // read-only and unmapped offsets ignore writes
                status_nxt = status_nxt;
            end
        end

        // instruction execution
        case (state_r)
            mrx_pkg::MRX_EXEC: begin
                state_nxt = mrx_pkg::MRX_IDLE;
                if (op_w == `MRX_OP_LOAD_BANK) begin
                    bank_select_reg_nxt = instr_r[4:0];
                end else if (op_w == `MRX_OP_LOAD_LATCH) begin
                    pc_high_latch_nxt = instr_r[6:0];
                end else if (op_w == `MRX_OP_LOAD_ACC) begin
                    acc_nxt = instr_r[7:0];
                end else if (op_w == `MRX_OP_STORE_FILE) begin
                    mem_we_nxt = 1'b1;
                    mem_wdata_nxt = acc_r;
                    // the two port addresses hold no storage of their own
                    if (file_w == `MRX_PORT0_ADDR) begin
                        mem_addr_nxt = pointer_reg_r[0];
                    end else if (file_w == `MRX_PORT1_ADDR) begin
                        mem_addr_nxt = pointer_reg_r[1];
                    end else begin
                        mem_addr_nxt = {4'h0, bank_select_reg_r, file_w};
                    end
                end else if (op_w == `MRX_OP_STORE_IND ||
                             op_w == `MRX_OP_STORE_REL) begin
                    mem_we_nxt = 1'b1;
                    mem_wdata_nxt = acc_r;
                    mem_addr_nxt = ind_addr_w;
                    pointer_reg_nxt[sel_w] = ind_ptr_w;
                end else if (op_w == `MRX_OP_OPTION) begin
                    option_nxt = acc_r;
                end else if (op_w == `MRX_OP_SW_RESET) begin
                    // device state returns to its reset values; the cause
                    // flag is driven low instead so firmware can tell why it restarted
                    dev_reset_nxt = 1'b1;
                    reset_instr_flag_nxt = 1'b0;
                    acc_nxt = `MRX_RST_ACC;
                    bank_select_reg_nxt = `MRX_RST_BANK;
                    pc_high_latch_nxt = `MRX_RST_LATCH;
                    pointer_reg_nxt[0] = `MRX_RST_PTR;
                    pointer_reg_nxt[1] = `MRX_RST_PTR;
                    option_nxt = `MRX_RST_OPTION;
                    irq_control_reg_nxt = `MRX_RST_IRQCTL;
                    pc_nxt = '0;
                    status_nxt = `MRX_RST_STATUS;
                end else if (op_w == `MRX_OP_RET_IRQ) begin
                    // first cycle: pop and take the top entry
                    stack_pop_nxt = 1'b1;
                    pc_nxt = stack_top_i;
                    state_nxt = mrx_pkg::MRX_RET2;
                end else begin
                    // no operation and unused opcodes
                    state_nxt = mrx_pkg::MRX_IDLE;
                end
            end
            mrx_pkg::MRX_RET2: begin
                // second cycle of the return
                irq_control_reg_nxt[`MRX_IRQ_EN_BIT] = 1'b1;
                state_nxt = mrx_pkg::MRX_IDLE;
            end
            default: begin
                state_nxt = state_nxt;
            end
        endcase
    end

    //------------------------------------------------------------------------
    // core: registers
    //------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= mrx_pkg::MRX_IDLE;
            instr_r <= 16'h0000;
            acc_r <= `MRX_RST_ACC;
            bank_select_reg_r <= `MRX_RST_BANK;
            pc_high_latch_r <= `MRX_RST_LATCH;
            pointer_reg_r[0] <= `MRX_RST_PTR;
            pointer_reg_r[1] <= `MRX_RST_PTR;
            option_r <= `MRX_RST_OPTION;
            reset_instr_flag_r <= 1'b1;
            irq_control_reg_r <= `MRX_RST_IRQCTL;
            pc_r <= '0;
            status_r <= `MRX_RST_STATUS;
            mem_we_r <= 1'b0;
            mem_addr_r <= 16'h0000;
            mem_wdata_r <= 8'h00;
            stack_pop_r <= 1'b0;
            dev_reset_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            instr_r <= instr_nxt;
            acc_r <= acc_nxt;
            bank_select_reg_r <= bank_select_reg_nxt;
            pc_high_latch_r <= pc_high_latch_nxt;
            pointer_reg_r[0] <= pointer_reg_nxt[0];
            pointer_reg_r[1] <= pointer_reg_nxt[1];
            option_r <= option_nxt;
            reset_instr_flag_r <= reset_instr_flag_nxt;
            irq_control_reg_r <= irq_control_reg_nxt;
            pc_r <= pc_nxt;
            status_r <= status_nxt;
            mem_we_r <= mem_we_nxt;
            mem_addr_r <= mem_addr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            stack_pop_r <= stack_pop_nxt;
            dev_reset_r <= dev_reset_nxt;
        end
    end

    //------------------------------------------------------------------------
    // outputs, all straight from flops
    //------------------------------------------------------------------------
    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hreadyout_r;
    assign hresp_o = hresp_r;
    assign stack_pop_o = stack_pop_r;
    assign pc_o = pc_r;
    assign mem_we_o = mem_we_r;
    assign mem_addr_o = mem_addr_r;
    assign mem_wdata_o = mem_wdata_r;
    assign dev_reset_req_o = dev_reset_r;
    assign global_irq_enable_o = irq_control_reg_r[`MRX_IRQ_EN_BIT];
endmodule

`default_nettype wire

/* mrx_exec_props.sv */
// Purpose: assertions on the executor outputs
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached to every executor instance by bind
`default_nettype none
module mrx_exec_props #(
    parameter int PC_W = 15 // pc width
) (
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic [PC_W-1:0] stack_top_i, // stack top
    input wire logic stack_pop_o, // pop pulse
    input wire logic [PC_W-1:0] pc_o, // pc
    input wire logic mem_we_o, // store strobe
    input wire logic [15:0] mem_addr_o, // store address
    input wire logic [7:0] mem_wdata_o, // store value
    input wire logic dev_reset_req_o, // reset request
    input wire logic global_irq_enable_o // irq enable
);
default clocking @(posedge clk_i);
endclocking
default disable iff (sys_rst_i);
pop_one_a: assert property (stack_pop_o |=> !stack_pop_o)
    else $error("pop pulse too long");
pc_load_a: assert property (
    stack_pop_o |-> pc_o == $past(stack_top_i)) else $error("pc not loaded");
pc_hold_a: assert property (stack_pop_o |=> $stable(pc_o))
    else $error("pc moved after return");
irq_en_set_a: assert property (stack_pop_o |=> global_irq_enable_o)
    else $error("irq enable not set");
we_one_a: assert property (mem_we_o |=> !mem_we_o)
    else $error("store strobe too long");
mem_hold_a: assert property (
    mem_we_o |=> $stable(mem_addr_o) && $stable(mem_wdata_o))
    else $error("store data not held");
rst_one_a: assert property (dev_reset_req_o |=> !dev_reset_req_o)
    else $error("reset pulse too long");
rst_irq_en_a: assert property (
    dev_reset_req_o |=> !global_irq_enable_o) else $error("irq enable kept");
endmodule
bind mrx_exec mrx_exec_props #(.PC_W(PC_W)) u_props (.clk_i, .sys_rst_i,
    .stack_top_i, .stack_pop_o, .pc_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .dev_reset_req_o, .global_irq_enable_o);
`default_nettype wire

/* test_move_return_instr_exec.sv */
// Purpose: self-checking bench of the move / return executor
// Assumes: zero-wait bus slave, 250 MHz clock
// Notes: stores are judged on the mem_ ports one cycle after issue
`include "mrx_defines.svh"
`default_nettype none
module test_move_return_instr_exec;
timeunit 1ns;
timeprecision 1ps;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
int num_errors = 0;
int comparisons = 0;
logic clk_i = 1'b0, sys_rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000;
logic [1:0] htrans_i = 2'b00;
logic [14:0] stack_top_i = 15'h5a3c;
logic [31:0] hrdata_o, q;
logic hreadyout_o, hresp_o, stack_pop_o, mem_we_o, dev_reset_req_o;
logic global_irq_enable_o;
logic [14:0] pc_o;
logic [15:0] mem_addr_o;
logic [7:0] mem_wdata_o;
always #2 clk_i = ~clk_i;
mrx_exec DUT (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .stack_top_i, .stack_pop_o,
    .pc_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .dev_reset_req_o,
    .global_irq_enable_o);
// one single word transfer: address phase, then data phase
task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    haddr_i <= 32'(a);
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
    `CHK("hresp", 1'b0, hresp_o)
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK($sformatf("reg %h", a), e, q)
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
endtask
// issue an instruction, return in the cycle after it has run
task automatic ex(input logic [15:0] i);
    wr(`MRX_OFF_INSTR, {16'h0000, i});
    repeat (2) @(negedge clk_i);
endtask
task automatic mc(input logic [15:0] a, input logic [7:0] d);
    `CHK("mem_we", 1'b1, mem_we_o)
    `CHK("mem_addr", a, mem_addr_o)
    `CHK("mem_wdata", d, mem_wdata_o)
endtask
task automatic t_reset;
    rd(`MRX_OFF_OPTION, 32'h0000_00ff);
    rd(`MRX_OFF_PWRCTL, 32'h0000_0004);
    rd(8'h40, 32'h0000_0000);
endtask
task automatic t_literals;
    // read straight after the issue; the bus write to the read-only bank register leaves the literal in place
    wr(`MRX_OFF_INSTR, 32'h0000_101f);
    rd(`MRX_OFF_BANK, 32'h0000_001f);
    wr(`MRX_OFF_BANK, 32'h0000_0003);
    rd(`MRX_OFF_BANK, 32'h0000_001f);
    ex(16'h207f);
    rd(`MRX_OFF_PCLATCH, 32'h0000_007f);
    ex(16'h30a5);
    rd(`MRX_OFF_ACC, 32'h0000_00a5);
    ex(16'h7000);
    rd(`MRX_OFF_OPTION, 32'h0000_00a5);
endtask
task automatic t_store;
    ex(16'h4055);
    mc(16'h0fd5, 8'ha5);
    wr(`MRX_OFF_PTR0, 32'h0000_1234);
    ex(16'h4000);
    mc(16'h1234, 8'ha5);
endtask
// every mode from the end of the range that makes the pointer wrap
task automatic t_indirect;
    logic [15:0] p, n;
    for (int m = 0; m < 4; m++) begin
        p = m[0] ? 16'h0000 : 16'hffff;
        n = m[0] ? p - 16'h0001 : p + 16'h0001;
        wr(`MRX_OFF_PTR1, {16'h0000, p});
        ex(16'h5100 | 16'(m));
        mc(m[1] ? p : n, 8'ha5);
        rd(`MRX_OFF_PTR1, {16'h0000, n});
    end
endtask
task automatic t_relative;
    wr(`MRX_OFF_PTR0, 32'h0000_0100);
    ex(16'h6020);
    mc(16'h00e0, 8'ha5);
    rd(`MRX_OFF_PTR0, 32'h0000_0100);
    rd(`MRX_OFF_STATUS, 32'h0000_0018);
endtask
task automatic t_irq;
    ex(16'h9000);
    `CHK("pop", 1'b1, stack_pop_o)
    `CHK("pc", 15'h5a3c, pc_o)
    @(negedge clk_i);
    `CHK("irq_en", 1'b1, global_irq_enable_o)
    rd(`MRX_OFF_IRQCTL, 32'h0000_0080);
endtask
task automatic t_swreset;
    ex(16'h8000);
    `CHK("reset req", 1'b1, dev_reset_req_o)
    rd(`MRX_OFF_PWRCTL, 32'h0000_0000);
    rd(`MRX_OFF_ACC, 32'h0000_0000);
endtask
task automatic stop_test;
    if (num_errors == 0 && comparisons > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_literals;
    t_store;
    t_indirect;
    t_relative;
    t_irq;
    t_swreset;
    stop_test;
end
// the run needs about half a microsecond; this cuts a hung handshake short
initial begin
    #20000;
    num_errors++;
    stop_test;
end
endmodule
`default_nettype wire
